// ---- shared/sept_pkg.sv ----
// Package: constants for the serial encoder position tracker
package sept_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL      = 8'h00; // Mode and command bits
  localparam logic [7:0] REG_RATIO     = 8'h04; // Units ratio numer/denom
  localparam logic [7:0] REG_POS_LIMIT = 8'h08; // Positive travel limit
  localparam logic [7:0] REG_NEG_LIMIT = 8'h0C; // Negative travel limit
  localparam logic [7:0] REG_HI_COUNT  = 8'h10; // High count limit
  localparam logic [7:0] REG_LO_COUNT  = 8'h14; // Low count limit
  localparam logic [7:0] REG_HOME_POS  = 8'h18; // Home position value
  localparam logic [7:0] REG_SET_POS   = 8'h1C; // Set position value
  localparam logic [7:0] REG_STATUS    = 8'h20; // Status bits
  localparam logic [7:0] REG_ACT_POS   = 8'h24; // Actual position
  localparam logic [7:0] REG_OFFSET    = 8'h28; // Absolute feedback offset
  localparam logic [7:0] REG_RESOL     = 8'h2C; // Counts per revolution
  localparam logic [7:0] REG_TARGET    = 8'h30; // Programmed target

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int CTRL_ABS      = 0; // Absolute feedback setting
  localparam int CTRL_CONT     = 1; // Continuous axis mode
  localparam int CTRL_HOME_DONE = 2; // Homing complete (write 1 pulse)
  localparam int CTRL_SET_POS  = 3; // Set position command (write 1 pulse)
  localparam int CTRL_HOME_MODE_LO = 4; // Homing mode, 2 bits

  // Status register fields
  localparam int STS_VALID     = 0; // Position valid
  localparam int STS_REFD      = 1; // Encoder referenced
  localparam int STS_OFS_OK    = 2; // Stored offset present
  localparam int STS_BATT_LOST = 3; // Encoder battery lost
  localparam int STS_BATT_LOW  = 4; // Encoder battery low
  localparam int STS_CFG_ERR   = 5; // Last ratio or positive limit write refused
  localparam int STS_HOME_REQ  = 6; // Reference operation required
  localparam int STS_TGT_CLIP  = 7; // Target clipped to travel limits

  // ----------------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------------
  localparam logic [31:0] MAX_POS_LIMIT = 32'h007F_FFFF; // +8,388,607
  localparam logic [7:0]  RATIO_MAX_UP  = 8'h08;  // 8:1 at most
  localparam logic [7:0]  RATIO_MAX_DN  = 8'h20;  // 1:32 at most
  localparam logic [31:0] DEF_COUNTS_REV = 32'h0000_2000; // 8192
  localparam logic [31:0] RST_HI_COUNT  = 32'h7FFF_FFFF;
  localparam logic [31:0] RST_LO_COUNT  = 32'h8000_0000;

  // Power-up sequencing states
  typedef enum logic [1:0] {
    SEPT_DIAG,   // Self-diagnostic
    SEPT_QUERY,  // Query encoder referenced status
    SEPT_READ,   // Read encoder absolute position
    SEPT_RUN     // Normal tracking
  } sept_state_t;

  // Last diagnostic timer count; the diagnostic lasts 16 cycles
  localparam logic [3:0] DIAG_CYCLES = 4'hF;

endpackage

// ---- hw/sept_tracker.sv ----
// Module: serial encoder position tracker with APB register slave
//
// Function
// - Linear: refuse positive limit above 8388607
// - Accept unit ratio only from 8:1 to 1:32
// - Default 8192 counts/rev unless tuning selects
// - Incremental: 8192/rev, marker once per revolution
// - Homing or set position marks axis valid
// - Incremental position wraps between count limits
// - Absolute homing: load home, store offset
// - Absolute set position: load CTRL write word, store offset
// - Stored offset restores position after power cycle
// - Power-up: diagnostic, query status, then read if absolute
// - Absolute position equals encoder plus offset
// - Absolute: rereference after battery loss unpowered
// - Continuous mode: no travel limit imposed
// - Continuous: incremental position rolls over at count limits
`timescale 1ns/10ps

module sept_tracker
  import sept_pkg::*;
#(
  parameter int POS_W = 32 // Position width
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              absolute_data_not_ready,
  input  wire logic [POS_W-1:0]  enc_abs_count,
  input  wire logic              enc_delta_valid,
  input  wire logic              enc_delta_up,
  input  wire logic              enc_marker,
  input  wire logic              enc_batt_lost,
  input  wire logic              enc_batt_low,
  input  wire logic              nv_offset_present,
  input  wire logic [POS_W-1:0]  nv_offset_in,
  output logic                   nv_store,
  output logic [POS_W-1:0]       nv_offset_out,
  output logic [POS_W-1:0]       actual_position,
  output logic                   position_valid
);

  // Elaboration check: the register map is built for 32-bit positions
  if (POS_W != 32) begin : g_width_check
    $error("POS_W must be 32");
  end

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic              abs_mode_ff;    // Absolute feedback setting
  logic              cont_mode_ff;   // Continuous axis mode
  logic [1:0]        home_mode_ff;   // Homing mode selection
  logic [7:0]        ratio_up_ff;    // Units per count numerator
  logic [7:0]        ratio_dn_ff;    // Units per count denominator
  logic [31:0]       pos_limit_ff;   // Positive travel limit
  logic [31:0]       neg_limit_ff;   // Negative travel limit
  logic [31:0]       hi_count_ff;    // High count limit
  logic [31:0]       lo_count_ff;    // Low count limit
  logic [31:0]       home_pos_ff;    // Home position
  logic [31:0]       set_pos_ff;     // Set position value
  logic [31:0]       resol_ff;       // Counts per revolution
  logic [31:0]       target_ff;      // Clipped programmed target
  logic              cfg_err_ff;     // Refused write flag
  logic              clip_ff;        // Target was clipped
  logic [POS_W-1:0]  offset_ff;      // Absolute feedback offset
  logic              ofs_ok_ff;      // Offset established
  logic [POS_W-1:0]  inc_pos_ff;     // Incremental position
  logic [POS_W-1:0]  rev_cnt_ff;     // Counts within revolution
  logic              valid_ff;       // Position valid
  logic              nv_store_ff;    // Offset store strobe
  logic [31:0]       prdata_ff;      // Read data
  logic              pready_ff;      // Access phase answer
  logic              pslverr_ff;     // Error answer
  sept_state_t       state_ff;       // Power-up sequencer
  logic [3:0]        diag_cnt_ff;    // Diagnostic timer
  logic              home_req_ff;    // Reference required

  logic              wr_en;          // Write in access cycle
  logic              rd_en;          // Read in setup cycle
  logic              home_cmd;       // Homing completion command
  logic              setp_cmd;       // Set position command
  logic [POS_W-1:0]  abs_pos;        // Encoder plus offset
  logic [POS_W-1:0]  nxt_ref_pos;    // Position to load on reference
  logic [POS_W-1:0]  nxt_inc_pos;    // Next incremental position
  logic              refd;           // Encoder referenced
  logic              addr_ok;        // Mapped address

  // Read data is captured in setup so it stands in the access cycle;
  // writes land only at the access edge where the master samples ready
  assign wr_en    = psel & penable & pwrite & pready_ff;
  assign rd_en    = psel & ~penable & ~pwrite;
  assign refd     = ~absolute_data_not_ready;
  assign home_cmd = wr_en && paddr == REG_CTRL && pwdata[CTRL_HOME_DONE];
  assign setp_cmd = wr_en && paddr == REG_CTRL && pwdata[CTRL_SET_POS];
  assign abs_pos  = enc_abs_count + offset_ff;
  assign nxt_ref_pos = home_cmd ? home_pos_ff : pwdata;
  assign addr_ok  = paddr[1:0] == 2'b00 && paddr <= REG_TARGET;

  // ----------------------------------------------------------------------
  // Incremental wrap between count limits
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_inc_pos = inc_pos_ff;
    if (enc_delta_valid) begin
      if (enc_delta_up) begin
        // Wrap high to low
        if ($signed(inc_pos_ff) >= $signed(hi_count_ff)) begin
          nxt_inc_pos = lo_count_ff;
        end else begin
          nxt_inc_pos = inc_pos_ff + 32'h0000_0001;
        end
      end else begin
        // Wrap low to high
        if ($signed(inc_pos_ff) <= $signed(lo_count_ff)) begin
          nxt_inc_pos = hi_count_ff;
        end else begin
          nxt_inc_pos = inc_pos_ff - 32'h0000_0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abs_mode_ff  <= 1'b0;
      cont_mode_ff <= 1'b0;
      home_mode_ff <= 2'h0;
      ratio_up_ff  <= 8'h01;
      ratio_dn_ff  <= 8'h01;
      pos_limit_ff <= MAX_POS_LIMIT;
      neg_limit_ff <= 32'hFF80_0001;
      hi_count_ff  <= RST_HI_COUNT;
      lo_count_ff  <= RST_LO_COUNT;
      home_pos_ff  <= 32'h0000_0000;
      set_pos_ff   <= 32'h0000_0000;
      resol_ff     <= DEF_COUNTS_REV;
      cfg_err_ff   <= 1'b0;
    end else if (wr_en) begin
      if (paddr == REG_CTRL) begin
        abs_mode_ff  <= pwdata[CTRL_ABS];
        cont_mode_ff <= pwdata[CTRL_CONT];
        home_mode_ff <= pwdata[CTRL_HOME_MODE_LO +: 2];
      end else if (paddr == REG_RATIO) begin
        // Either side must be 1 and other within 8 up or 32 down
        if ((pwdata[15:8] == 8'h01 && pwdata[7:0] != 8'h00 &&
             pwdata[7:0] <= RATIO_MAX_UP) ||
            (pwdata[7:0] == 8'h01 && pwdata[15:8] != 8'h00 &&
             pwdata[15:8] <= RATIO_MAX_DN)) begin
          ratio_up_ff <= pwdata[7:0];
          ratio_dn_ff <= pwdata[15:8];
          cfg_err_ff  <= 1'b0;
        end else begin
          cfg_err_ff  <= 1'b1;
        end
      end else if (paddr == REG_POS_LIMIT) begin
        // Linear mode refuses values above the limit
        if (!cont_mode_ff && $signed(pwdata) > $signed(MAX_POS_LIMIT)) begin
          cfg_err_ff   <= 1'b1;
        end else begin
          pos_limit_ff <= pwdata;
          cfg_err_ff   <= 1'b0;
        end
      end else if (paddr == REG_NEG_LIMIT) begin
        neg_limit_ff <= pwdata;
      end else if (paddr == REG_HI_COUNT) begin
        hi_count_ff  <= pwdata;
      end else if (paddr == REG_LO_COUNT) begin
        lo_count_ff  <= pwdata;
      end else if (paddr == REG_HOME_POS) begin
        home_pos_ff  <= pwdata;
      end else if (paddr == REG_SET_POS) begin
        set_pos_ff   <= pwdata;
      end else if (paddr == REG_RESOL) begin
        // Tuning selects another resolution; zero restores the default
        resol_ff <= (pwdata == 32'h0) ? DEF_COUNTS_REV : pwdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Programmed target bounded by travel limits in linear mode
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_ff <= 32'h0000_0000;
      clip_ff   <= 1'b0;
    end else if (wr_en && paddr == REG_TARGET) begin
      if (cont_mode_ff) begin
        target_ff <= pwdata;
        clip_ff   <= 1'b0;
      end else if ($signed(pwdata) > $signed(pos_limit_ff)) begin
        target_ff <= pos_limit_ff;
        clip_ff   <= 1'b1;
      end else if ($signed(pwdata) < $signed(neg_limit_ff)) begin
        target_ff <= neg_limit_ff;
        clip_ff   <= 1'b1;
      end else begin
        target_ff <= pwdata;
        clip_ff   <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Power-up sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff    <= SEPT_DIAG;
      diag_cnt_ff <= 4'h0;
    end else begin
      case (state_ff)
        SEPT_DIAG: begin
          // Self-diagnostic before touching the encoder
          diag_cnt_ff <= diag_cnt_ff + 4'h1;
          if (diag_cnt_ff == DIAG_CYCLES) begin
            state_ff <= SEPT_QUERY;
          end
        end
        SEPT_QUERY: begin
          // Read position only once encoder says referenced
          if (!abs_mode_ff) begin
            state_ff <= SEPT_RUN;
          end else if (refd) begin
            state_ff <= SEPT_READ;
          end
        end
        SEPT_READ: begin
          state_ff <= SEPT_RUN;
        end
        default: begin
          state_ff <= SEPT_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Offset store and reference requirement
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_ff   <= '0;
      ofs_ok_ff   <= 1'b0;
      nv_store_ff <= 1'b0;
      home_req_ff <= 1'b1;
    end else begin
      nv_store_ff <= 1'b0;
      if (abs_mode_ff && (home_cmd || setp_cmd) && refd) begin
        // Offset that makes encoder count read as the loaded value
        offset_ff   <= nxt_ref_pos - enc_abs_count;
        ofs_ok_ff   <= 1'b1;
        nv_store_ff <= 1'b1;
        home_req_ff <= 1'b0;
      end else if (state_ff == SEPT_READ) begin
        // Restore stored offset; it counts as valid only if the battery stayed on
        offset_ff   <= nv_offset_in;
        ofs_ok_ff   <= nv_offset_present & ~enc_batt_lost;
        home_req_ff <= ~nv_offset_present | enc_batt_lost;
      end else if (abs_mode_ff && enc_batt_lost) begin
        ofs_ok_ff   <= 1'b0;
        home_req_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Incremental position and marker tracking
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inc_pos_ff <= '0;
      rev_cnt_ff <= '0;
    end else begin
      if (home_cmd || setp_cmd) begin
        inc_pos_ff <= nxt_ref_pos;
      end else begin
        inc_pos_ff <= nxt_inc_pos;
      end
      // Marker equivalent aligns the revolution counter
      if (enc_marker) begin
        rev_cnt_ff <= '0;
      end else if (enc_delta_valid) begin
        if (enc_delta_up) begin
          rev_cnt_ff <= (rev_cnt_ff == resol_ff - 32'h1) ? '0
                        : rev_cnt_ff + 32'h1;
        end else begin
          rev_cnt_ff <= (rev_cnt_ff == '0) ? resol_ff - 32'h1
                        : rev_cnt_ff - 32'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Position valid
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_ff <= 1'b0;
    end else if (abs_mode_ff) begin
      if (!refd || !ofs_ok_ff) begin
        valid_ff <= 1'b0;
      end else if (state_ff == SEPT_RUN) begin
        valid_ff <= 1'b1;
      end
    end else if (home_cmd || setp_cmd) begin
      valid_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // APB slave answer
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel & ~penable;
      pslverr_ff <= psel & ~penable & ~addr_ok;
      if (rd_en) begin
        if (paddr == REG_CTRL) begin
          prdata_ff <= {26'h0, home_mode_ff, 2'b00, cont_mode_ff,
                        abs_mode_ff};
        end else if (paddr == REG_RATIO) begin
          prdata_ff <= {16'h0, ratio_dn_ff, ratio_up_ff};
        end else if (paddr == REG_POS_LIMIT) begin
          prdata_ff <= pos_limit_ff;
        end else if (paddr == REG_NEG_LIMIT) begin
          prdata_ff <= neg_limit_ff;
        end else if (paddr == REG_HI_COUNT) begin
          prdata_ff <= hi_count_ff;
        end else if (paddr == REG_LO_COUNT) begin
          prdata_ff <= lo_count_ff;
        end else if (paddr == REG_HOME_POS) begin
          prdata_ff <= home_pos_ff;
        end else if (paddr == REG_SET_POS) begin
          prdata_ff <= set_pos_ff;
        end else if (paddr == REG_STATUS) begin
          // Battery flags come straight from the encoder
          prdata_ff <= {24'h0, clip_ff, home_req_ff, cfg_err_ff,
                        enc_batt_low, enc_batt_lost, ofs_ok_ff, refd,
                        valid_ff};
        end else if (paddr == REG_ACT_POS) begin
          prdata_ff <= actual_position;
        end else if (paddr == REG_OFFSET) begin
          prdata_ff <= offset_ff;
        end else if (paddr == REG_RESOL) begin
          prdata_ff <= resol_ff;
        end else if (paddr == REG_TARGET) begin
          prdata_ff <= target_ff;
        end else begin
          prdata_ff <= 32'h0000_0000;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registered position outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      actual_position <= '0;
    end else if (abs_mode_ff) begin
      actual_position <= abs_pos;
    end else begin
      actual_position <= inc_pos_ff;
    end
  end

  assign prdata         = prdata_ff;
  assign pready         = pready_ff;
  assign pslverr        = pslverr_ff;
  assign nv_store       = nv_store_ff;
  assign nv_offset_out  = offset_ff;
  assign position_valid = valid_ff;

endmodule

// ---- tb/sept_enc_model.sv ----
// Behavioural model of the battery-backed serial encoder
`timescale 1ns/10ps
module sept_enc_model #(
  parameter int REF_AT = 3,         // Steps until the reference point
  parameter int CPR    = 8192,      // Counts per revolution
  parameter int SPAN   = 268427264  // Absolute counting range
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        batt_on,
  input  wire logic        batt_weak,
  input  wire logic        step_up,
  input  wire logic        step_dn,
  output logic             not_ready,
  output logic [31:0]      abs_count,
  output logic             dv,
  output logic             up,
  output logic             marker,
  output logic             batt_lost,
  output logic             batt_low
);
  int seen; // Steps taken since power-up or reference loss, the referencing step excluded
  initial begin
    not_ready = 1'b1;
    abs_count = 32'h0;
    seen = 0;
    {dv, up, marker} = 3'h0;
  end
  // Step pulses, referencing and rollover of the absolute count
  always @(posedge pclk) begin
    dv <= step_up || step_dn;
    up <= step_up;
    marker <= 1'b0;
    if (step_up || step_dn) begin
      if (not_ready && seen + 1 >= REF_AT) begin
        not_ready <= 1'b0;
        abs_count <= 32'h0;
      end else begin
        abs_count <= step_up ? (abs_count + 1) % SPAN
                             : (abs_count + SPAN - 1) % SPAN;
        seen <= seen + 1;
        marker <= ((abs_count + 1) % CPR) == 0;
      end
    end
  end
  // Without battery each power cycle loses the reference
  always @(negedge presetn) begin
    if (!batt_on) begin
      not_ready <= 1'b1;
      seen <= 0;
    end
  end
  assign batt_lost = !batt_on;
  assign batt_low  = batt_weak;
endmodule

// ---- tb/sept_tracker_sva.sv ----
// Port checker for the position tracker
`timescale 1ns/10ps
module sept_tracker_chk
  import sept_pkg::*;
#(
  parameter int POS_W = 32 // Position width
) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic             nv_store,
  input wire logic [POS_W-1:0] nv_offset_out,
  input wire logic [POS_W-1:0] actual_position,
  input wire logic             position_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic setup; // Setup phase of a transfer
  assign setup = psel && !penable;
  chk_apb_answer:
    assert property (setup |=> pready) else $error("no answer");
  chk_apb_cause:
    assert property (pready |-> $past(setup)) else $error("stray ready");
  chk_apb_single:
    assert property (pready |=> !pready) else $error("ready too long");
  chk_unmapped_err:
    assert property (setup && paddr > 8'h30 |=> pslverr)
      else $error("no slave error");
  chk_err_zero:
    assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("error read not zero");
  chk_nv_pulse:
    assert property (nv_store |=> !nv_store) else $error("store too long");
  chk_store_valid:
    assert property (nv_store |-> ##[0:2] position_valid)
      else $error("valid missing after store");
  chk_ofs_read:
    assert property (setup && !pwrite && paddr == REG_OFFSET
      |=> prdata == $past(nv_offset_out)) else $error("offset read");
  chk_act_read:
    assert property (setup && !pwrite && paddr == REG_ACT_POS
      |=> prdata == $past(actual_position)) else $error("position read");
  cover property (nv_store);
  cover property (pslverr);
  cover property ($rose(position_valid));
endmodule
bind sept_tracker sept_tracker_chk #(.POS_W(POS_W)) chk_u (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .nv_store,
  .nv_offset_out, .actual_position, .position_valid);

// ---- tb/testbench.sv ----
// Self-checking bench for the position tracker
`timescale 1ns/10ps
module testbench;
  import sept_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic nrdy, dv, up, mk, lost, low, nvp, nvs, pv, su, sd, bon, bw;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, v, enc, nv_in, nv_out, act;
  logic [31:0] rt [4] = '{32'h2001, 32'h2101, 32'h0108, 32'h0109};
  logic [31:0] re [4] = '{32'h2001, 32'h2001, 32'h0108, 32'h0108};
  int fails = 0, checks = 0, stores = 0;
  sept_tracker dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .absolute_data_not_ready(nrdy),
    .enc_abs_count(enc), .enc_delta_valid(dv), .enc_delta_up(up),
    .enc_marker(mk), .enc_batt_lost(lost), .enc_batt_low(low),
    .nv_offset_present(nvp), .nv_offset_in(nv_in), .nv_store(nvs),
    .nv_offset_out(nv_out), .actual_position(act), .position_valid(pv));
  sept_enc_model enc_u (.pclk, .presetn, .batt_on(bon), .batt_weak(bw),
    .step_up(su), .step_dn(sd), .not_ready(nrdy), .abs_count(enc), .dv,
    .up, .marker(mk), .batt_lost(lost), .batt_low(low));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) if (nvs === 1'b1) stores++;
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One APB transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) fails++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic steps(input logic dir, input int k);
    repeat (k) begin
      su <= dir;
      sd <= !dir;
      @(posedge pclk);
    end
    su <= 1'b0;
    sd <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic pwr(input logic b);
    bon <= b;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    test_done;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, su, sd, bw, nvp} = '0;
    {nv_in, presetn, bon} = {32'h0, 1'b0, 1'b1};
    pwr(1'b1);
    apb(0, REG_HI_COUNT, 0);
    chk("hi_count", q, RST_HI_COUNT);
    apb(0, 8'h34, 0);
    chk("unmapped", {31'h0, err}, 32'h1);
    $display("test defaults done");
    steps(1, 5);
    apb(0, REG_STATUS, 0);
    chk("refd", {31'h0, q[STS_REFD]}, 32'h1);
    apb(1, REG_CTRL, 32'h1);
    for (int m = 0; m < 3; m++) begin
      v = 32'h100 * (m + 1);
      apb(1, REG_HOME_POS, v);
      apb(1, REG_CTRL, 32'h5 | (32'(m) << 4));
      repeat (3) @(posedge pclk);
      chk("home_pos", act, v);
      chk("home_ofs", nv_out, v - 32'h2);
      chk("home_valid", {31'h0, pv}, 32'h1);
    end
    v = 32'h1009;
    apb(1, REG_CTRL, v);
    repeat (3) @(posedge pclk);
    chk("set_pos", act, v);
    chk("set_ofs", nv_out, v - 32'h2);
    chk("stores", 32'(stores), 32'h4);
    apb(0, REG_OFFSET, 0);
    chk("ofs_reg", q, v - 32'h2);
    apb(0, REG_ACT_POS, 0);
    chk("act_reg", q, v);
    steps(1, 5);
    chk("abs_track", act, v + 32'h5);
    $display("test absolute reference done");
    nvp <= 1'b1;
    nv_in <= v - 32'h2;
    pwr(1'b1);
    apb(1, REG_CTRL, 32'h1);
    repeat (60) if (pv !== 1'b1) @(posedge pclk);
    repeat (2) @(posedge pclk);
    chk("restore_valid", {31'h0, pv}, 32'h1);
    chk("restore_pos", act, v + 32'h5);
    pwr(1'b0);
    bw <= 1'b1;
    apb(1, REG_CTRL, 32'h1);
    repeat (40) @(posedge pclk);
    chk("lost_valid", {31'h0, pv}, 32'h0);
    apb(0, REG_STATUS, 0);
    chk("batt_lost", {31'h0, q[STS_BATT_LOST]}, 32'h1);
    chk("batt_low", {31'h0, q[STS_BATT_LOW]}, 32'h1);
    chk("ref_req", {31'h0, q[STS_HOME_REQ]}, 32'h1);
    $display("test power cycles done");
    apb(1, REG_HI_COUNT, 32'hA);
    apb(1, REG_LO_COUNT, 32'h0);
    apb(1, REG_CTRL, 32'h0);
    apb(1, REG_CTRL, 32'h8);
    steps(1, 3);
    chk("wrap_up", act, 32'h0);
    chk("inc_valid", {31'h0, pv}, 32'h1);
    steps(0, 1);
    chk("wrap_dn", act, 32'hA);
    apb(1, REG_CTRL, 32'hA);
    steps(1, 1);
    chk("cont_roll", act, 32'h0);
    apb(1, REG_POS_LIMIT, MAX_POS_LIMIT + 32'h1);
    apb(0, REG_POS_LIMIT, 0);
    chk("cont_limit", q, MAX_POS_LIMIT + 32'h1);
    apb(1, REG_CTRL, 32'h0);
    apb(1, REG_POS_LIMIT, MAX_POS_LIMIT);
    apb(1, REG_POS_LIMIT, MAX_POS_LIMIT + 32'h1);
    apb(0, REG_POS_LIMIT, 0);
    chk("lin_limit", q, MAX_POS_LIMIT);
    apb(1, REG_TARGET, MAX_POS_LIMIT + 32'h1);
    apb(0, REG_TARGET, 0);
    chk("target_clip", q, MAX_POS_LIMIT);
    foreach (rt[i]) begin
      apb(1, REG_RATIO, rt[i]);
      apb(0, REG_RATIO, 0);
      chk("ratio", q, re[i]);
    end
    apb(0, REG_STATUS, 0);
    chk("cfg_err", {31'h0, q[STS_CFG_ERR]}, 32'h1);
    $display("test counts and limits done");
    test_done;
  end
endmodule
